// file: verilog/cfps_core.sv
// Purpose: flag register, option and trim registers, pc sequencing and return stack
// Assumes: execution logic presents one operation per executing cycle
// Notes:   outputs registered except tick_div_exp, option bits 2..0 plus one; ce low freezes every flip-flop
// Function
// - pin-change wake reset sets pin wake flag; other resets clear it.
// - comparator wake reset sets comparator wake flag; other resets clear it.
// - timeout_n is one after power-up, clear-watchdog, sleep; zero on watchdog timeout.
// - powerdown_n one after power-up or clear-watchdog; zero on sleep.
// - zero flag follows whether the arithmetic or logic result is zero.
// - digit carry is nibble carry on add, nibble no-borrow on subtract.
// - carry is carry on add, no-borrow on subtract, shifted-out bit on rotates.
// - write-only option register loaded from W, all ones on any reset.
// - output-direction pins get no wake-on-change and no pull-up.
// - option bits 7 and 6, active low, enable wake and pull-ups.
// - option bit 5 picks external tick pin or instruction clock for counter.
// - option bit 4 picks falling edges, else rising edges, of tick pin.
// - option bit 3 gives prescaler to watchdog, else to tick counter.
// - tick counter divides by 2^(n+1), watchdog by 2^n.
// - trim bits 7..1 are a signed oscillator trim code.
// - trim bit 0 drives oscillator/4 onto pin two, overriding all else.
// - pc advances by one each executed instruction unless loaded.
// - jump loads pc bits 8..0 from the instruction word.
// - call and pc-low writes load bits 7..0 and clear bit 8.
// - reset sets pc to all ones; it then rolls over to zero.
// - call pushes level 1 to level 2, pc+1 to level 1; no flags.
// - return loads pc from level 1, copies level 2 down, loads W literal.
// - written zero, digit carry, carry are ignored when the op sets them.
module cfps_core
	import cfps_pkg::*;
#(
	parameter int PC_W = 9
)(
	// clock and reset
	input  wire logic              clk_sys,
	input  wire logic              nrst,
	input  wire logic              ce,
	// register port
	input  wire logic [1:0]        reg_addr,
	input  wire logic [7:0]        reg_wdata,
	input  wire logic              reg_wr,
	input  wire logic              reg_rd,
	output logic      [7:0]        reg_rdata,
	// execution side
	input  wire logic              ex_valid,
	input  wire cfps_op_e          ex_op,
	input  wire logic [7:0]        ex_a,
	input  wire logic [7:0]        ex_b,
	input  wire logic [PC_W-1:0]   ex_lit,
	input  wire logic [7:0]        w_in,
	input  wire logic              wdt_timeout,
	output logic      [PC_W-1:0]   pc,
	output logic      [7:0]        alu_result,
	output logic      [7:0]        w_out,
	output logic                   w_load,
	// other resets and their cause
	input  wire logic              sys_rst,
	input  wire logic              rst_pin_wake,
	input  wire logic              rst_cmp_wake,
	// pin control
	input  wire logic [2:0]        dir_ctrl,
	input  wire logic              ext_tick_pin,
	input  wire logic              pin_two_norm_o,
	input  wire logic              pin_two_norm_oe,
	output logic      [2:0]        pin_wake_en,
	output logic      [2:0]        pullup_en,
	output logic                   tick_pulse,
	output logic                   ext_tick_dir_override,
	output logic                   prescale_to_wdt,
	output logic      [3:0]        tick_div_exp,
	output logic      [3:0]        wdt_div_exp,
	output logic      [6:0]        osc_trim_value,
	output logic                   pin_two_o,
	output logic                   pin_two_oe
);

	typedef struct packed {
		logic [7:0]      flags;
		logic [7:0]      option;
		logic [7:0]      trim;
		logic [PC_W-1:0] pc;
		logic [PC_W-1:0] stk1;
		logic [PC_W-1:0] stk2;
		logic [7:0]      rdata;
		logic [7:0]      result;
		logic [7:0]      w_out;
		logic            w_load;
		logic [1:0]      qdiv;
		logic            tick_prev;
		logic            tick_pulse;
		logic [2:0]      wake_en;
		logic [2:0]      pull_en;
		logic            pin_o;
		logic            pin_oe;
	} cfps_state_s;

	cfps_state_s s_reg;
	cfps_state_s s_next;

	always_comb
	begin
		logic [8:0] sum9;
		logic [4:0] nib5;
		logic       upd;
		logic       exe;
		logic [7:0] res;
		sum9 = 9'h000;
		nib5 = 5'h00;
		upd  = 1'b0;
		exe  = ex_valid;
		res  = ex_a;
		s_next = s_reg;
		s_next.w_load = 1'b0;
		s_next.rdata = 8'h00;
		if (reg_rd)
		begin
			case (reg_addr)
				CFPS_OFS_FLAGS:  s_next.rdata = s_reg.flags;
				CFPS_OFS_TRIM:   s_next.rdata = s_reg.trim;
				CFPS_OFS_PCLOW:  s_next.rdata = s_reg.pc[7:0];
				default:         s_next.rdata = 8'h00; // option is write-only
			endcase
		end
		// alu flag and result computation
		case (ex_op)
			CFPS_OP_ADD:
			begin
				sum9 = {1'b0, ex_a} + {1'b0, ex_b};
				nib5 = {1'b0, ex_a[3:0]} + {1'b0, ex_b[3:0]};
				res = sum9[7:0];
				upd = exe;
			end
			CFPS_OP_SUB:
			begin
				// a - b; bit 8 / bit 4 high means no borrow occurred
				sum9 = {1'b0, ex_a} + {1'b0, ~ex_b} + 9'h001;
				nib5 = {1'b0, ex_a[3:0]} + {1'b0, ~ex_b[3:0]} + 5'h01;
				res = sum9[7:0];
				upd = exe;
			end
			CFPS_OP_ROR:
				res = {s_reg.flags[CFPS_FB_CARRY], ex_a[7:1]};
			CFPS_OP_ROL:
				res = {ex_a[6:0], s_reg.flags[CFPS_FB_CARRY]};
			default:
				res = ex_a;
		endcase
		// software write; hardware updates below take priority
		if (reg_wr && reg_addr == CFPS_OFS_FLAGS)
			s_next.flags = (reg_wdata & CFPS_FLAG_WMASK) | (s_reg.flags & ~CFPS_FLAG_WMASK);
		if (reg_wr && reg_addr == CFPS_OFS_TRIM)
			s_next.trim = reg_wdata;
		if (reg_wr && reg_addr == CFPS_OFS_OPTION)
			s_next.option = reg_wdata;
		if (exe)
		begin
			s_next.result = res;
			s_next.pc = s_reg.pc + PC_W'(1);
			case (ex_op)
				CFPS_OP_ADD, CFPS_OP_SUB:
				begin
					s_next.flags[CFPS_FB_ZERO]   = (res == 8'h00);
					s_next.flags[CFPS_FB_DCARRY] = nib5[4];
					s_next.flags[CFPS_FB_CARRY]  = sum9[8];
				end
				CFPS_OP_ROR:
					s_next.flags[CFPS_FB_CARRY] = ex_a[0];
				CFPS_OP_ROL:
					s_next.flags[CFPS_FB_CARRY] = ex_a[7];
				CFPS_OP_LOGIC:
					s_next.flags[CFPS_FB_ZERO] = (res == 8'h00);
				CFPS_OP_JUMP:
					s_next.pc = ex_lit;
				CFPS_OP_CALL:
				begin
					s_next.stk2 = s_reg.stk1;
					s_next.stk1 = s_reg.pc + PC_W'(1);
					s_next.pc = {1'b0, ex_lit[PC_W-2:0]};
					s_next.pc[PC_W-1] = 1'b0;
					s_next.pc[7:0] = ex_lit[7:0];
				end
				CFPS_OP_RETLIT:
				begin
					s_next.pc = s_reg.stk1;
					s_next.stk1 = s_reg.stk2;
					s_next.w_out = ex_lit[7:0];
					s_next.w_load = 1'b1;
				end
				CFPS_OP_OPTION:
					s_next.option = w_in;
				CFPS_OP_WRPCL:
				begin
					s_next.pc = '0;
					s_next.pc[7:0] = ex_a;
				end
				CFPS_OP_WATCHDOG_CLEAR_OP:
				begin
					s_next.flags[CFPS_FB_TIMEOUT] = 1'b1;
					s_next.flags[CFPS_FB_PWRDN]   = 1'b1;
				end
				CFPS_OP_SLEEP:
				begin
					s_next.flags[CFPS_FB_TIMEOUT] = 1'b1;
					s_next.flags[CFPS_FB_PWRDN]   = 1'b0;
				end
				default:
					s_next.result = res;
			endcase
		end
		// a timeout in the clear cycle is not lost
		if (wdt_timeout)
			s_next.flags[CFPS_FB_TIMEOUT] = 1'b0;
		s_next.flags[5] = 1'b0;
		if (sys_rst)
		begin
			s_next.pc = '1;
			s_next.option = CFPS_RST_OPTION;
			s_next.flags[CFPS_FB_PINWAKE] = rst_pin_wake;
			s_next.flags[CFPS_FB_CMPWAKE] = rst_cmp_wake;
			s_next.w_load = 1'b0;
		end
		// pin side, computed from the settled registers
		s_next.wake_en = dir_ctrl & {3{~s_reg.option[CFPS_OB_WAKE_N]}};
		s_next.pull_en = dir_ctrl & {3{~s_reg.option[CFPS_OB_PULL_N]}};
		s_next.tick_prev = ext_tick_pin;
		if (s_reg.option[CFPS_OB_TSRC])
			s_next.tick_pulse = s_reg.option[CFPS_OB_TEDGE]
				? (s_reg.tick_prev & ~ext_tick_pin)
				: (~s_reg.tick_prev & ext_tick_pin);
		else
			s_next.tick_pulse = 1'b1;
		s_next.qdiv = s_reg.qdiv + 2'h1;
		// quarter clock wins over every other user of pin two
		s_next.pin_o  = s_reg.trim[CFPS_TB_QCLK] ? s_reg.qdiv[1] : pin_two_norm_o;
		s_next.pin_oe = s_reg.trim[CFPS_TB_QCLK] | pin_two_norm_oe;
	end

	always_ff @(posedge clk_sys or negedge nrst)
	begin
		if (!nrst)
		begin
			s_reg <= '0;
			s_reg.flags <= CFPS_RST_FLAGS;
			s_reg.option <= CFPS_RST_OPTION;
			s_reg.trim <= CFPS_RST_TRIM;
			s_reg.pc <= '1;
			s_reg.tick_pulse <= 1'b0;
		end
		else if (ce)
			s_reg <= s_next;
	end

	assign reg_rdata      = s_reg.rdata;
	assign pc             = s_reg.pc;
	assign alu_result     = s_reg.result;
	assign w_out          = s_reg.w_out;
	assign w_load         = s_reg.w_load;
	assign pin_wake_en    = s_reg.wake_en;
	assign pullup_en      = s_reg.pull_en;
	assign tick_pulse     = s_reg.tick_pulse;
	assign ext_tick_dir_override = s_reg.option[CFPS_OB_TSRC];
	assign prescale_to_wdt = s_reg.option[CFPS_OB_PSA];
	assign tick_div_exp   = {1'b0, s_reg.option[2:0]} + 4'h1;
	assign wdt_div_exp    = {1'b0, s_reg.option[2:0]};
	assign osc_trim_value = s_reg.trim[7:1];
	assign pin_two_o      = s_reg.pin_o;
	assign pin_two_oe     = s_reg.pin_oe;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);

	a_pc_advance: assert property (ce && ex_valid && ex_op == CFPS_OP_ADD && !sys_rst
		|=> pc == $past(pc) + PC_W'(1)) else $error("pc did not advance");
	a_jump_load: assert property (ce && ex_valid && ex_op == CFPS_OP_JUMP && !sys_rst
		|=> pc == $past(ex_lit)) else $error("jump target wrong");
	a_call_push: assert property (ce && ex_valid && ex_op == CFPS_OP_CALL && !sys_rst
		|=> pc[PC_W-1] == 1'b0 && s_reg.stk1 == $past(pc) + PC_W'(1)
		&& s_reg.stk2 == $past(s_reg.stk1)) else $error("call push wrong");
	a_ret_pop: assert property (ce && ex_valid && ex_op == CFPS_OP_RETLIT && !sys_rst
		|=> pc == $past(s_reg.stk1) && w_load && w_out == $past(ex_lit[7:0]))
		else $error("return pop wrong");
	a_rst_pc_ones: assert property (ce && sys_rst |=> pc == '1
		&& s_reg.option == CFPS_RST_OPTION) else $error("reset pc not all ones");
	a_timeout_clr: assert property (ce && wdt_timeout && !sys_rst
		|=> !s_reg.flags[CFPS_FB_TIMEOUT]) else $error("timeout lost");
	a_sleep_pd: assert property (ce && ex_valid && ex_op == CFPS_OP_SLEEP && !wdt_timeout
		&& !sys_rst |=> !s_reg.flags[CFPS_FB_PWRDN] && s_reg.flags[CFPS_FB_TIMEOUT])
		else $error("sleep flags wrong");
	a_add_carry: assert property (ce && ex_valid && ex_op == CFPS_OP_ADD && !sys_rst
		|=> s_reg.flags[CFPS_FB_CARRY] == ($past({1'b0, ex_a}) + $past({1'b0, ex_b}) > 9'h0ff))
		else $error("add carry wrong");
	a_wake_gate: assert property (ce ##1 ce |-> (pin_wake_en & ~$past(dir_ctrl)) == 3'h0)
		else $error("wake enabled on output pin");
	a_qclk_pin: assert property (ce && s_reg.trim[CFPS_TB_QCLK] |=> pin_two_oe)
		else $error("quarter clock not driven");
	a_wake_flag: assert property (ce && sys_rst |=>
		s_reg.flags[CFPS_FB_PINWAKE] == $past(rst_pin_wake)) else $error("wake flag wrong");

	a_cmp_flag: assert property (ce && sys_rst |=>
		s_reg.flags[CFPS_FB_CMPWAKE] == $past(rst_cmp_wake)) else $error("cmp flag wrong");

	// arithmetic flags, worked out from the operands rather than from the alu path
	a_sub_carry: assert property (ce && ex_valid && ex_op == CFPS_OP_SUB && !sys_rst
		|=> s_reg.flags[CFPS_FB_CARRY] == ($past(ex_a) >= $past(ex_b)))
		else $error("sub carry wrong");

	a_sub_dcarry: assert property (ce && ex_valid && ex_op == CFPS_OP_SUB && !sys_rst
		|=> s_reg.flags[CFPS_FB_DCARRY] == ($past(ex_a[3:0]) >= $past(ex_b[3:0])))
		else $error("sub digit carry wrong");

	a_add_dcarry: assert property (ce && ex_valid && ex_op == CFPS_OP_ADD && !sys_rst
		|=> s_reg.flags[CFPS_FB_DCARRY]
		== ($past({1'b0, ex_a[3:0]}) + $past({1'b0, ex_b[3:0]}) > 5'h0f))
		else $error("add digit carry wrong");

	a_add_zero: assert property (ce && ex_valid && ex_op == CFPS_OP_ADD && !sys_rst
		|=> s_reg.flags[CFPS_FB_ZERO] == ($past(ex_a) + $past(ex_b) == 8'h00))
		else $error("add zero wrong");

	a_logic_zero: assert property (ce && ex_valid && ex_op == CFPS_OP_LOGIC && !sys_rst
		|=> s_reg.flags[CFPS_FB_ZERO] == ($past(ex_a) == 8'h00))
		else $error("logic zero wrong");

	a_ror_carry: assert property (ce && ex_valid && ex_op == CFPS_OP_ROR && !sys_rst
		|=> s_reg.flags[CFPS_FB_CARRY] == $past(ex_a[0]))
		else $error("ror carry wrong");

	a_rol_carry: assert property (ce && ex_valid && ex_op == CFPS_OP_ROL && !sys_rst
		|=> s_reg.flags[CFPS_FB_CARRY] == $past(ex_a[7]))
		else $error("rol carry wrong");

	// sequencing and stack
	a_pc_hold: assert property (ce && !ex_valid && !sys_rst
		|=> pc == $past(pc)) else $error("pc moved while idle");

	a_wrpcl_load: assert property (ce && ex_valid && ex_op == CFPS_OP_WRPCL && !sys_rst
		|=> pc == PC_W'($past(ex_a))) else $error("pc low write wrong");

	a_ret_stack: assert property (ce && ex_valid && ex_op == CFPS_OP_RETLIT && !sys_rst
		|=> s_reg.stk1 == $past(s_reg.stk2) && s_reg.stk2 == $past(s_reg.stk2))
		else $error("return stack wrong");

	// option and reset-cause flags
	a_option_load: assert property (ce && ex_valid && ex_op == CFPS_OP_OPTION && !sys_rst
		|=> s_reg.option == $past(w_in)) else $error("option load wrong");

	a_watchdog_clear_op_flags: assert property (ce && ex_valid && ex_op == CFPS_OP_WATCHDOG_CLEAR_OP
		&& !wdt_timeout && !sys_rst
		|=> s_reg.flags[CFPS_FB_TIMEOUT] && s_reg.flags[CFPS_FB_PWRDN])
		else $error("clear watchdog flags wrong");

	// pin side lags the option register by one cycle
	a_pull_gate: assert property (ce ##1 ce |-> (pullup_en & ~$past(dir_ctrl)) == 3'h0)
		else $error("pull-up on output pin");

	a_pull_enable: assert property (ce ##1 ce |-> pullup_en
		== ($past(dir_ctrl) & {3{~$past(s_reg.option[CFPS_OB_PULL_N])}}))
		else $error("pull-up enable wrong");

	a_tick_internal: assert property (ce && !s_reg.option[CFPS_OB_TSRC]
		|=> tick_pulse) else $error("internal tick missing");

	a_tick_rise: assert property (ce && s_reg.option[CFPS_OB_TSRC]
		&& !s_reg.option[CFPS_OB_TEDGE] && !s_reg.tick_prev && ext_tick_pin
		|=> tick_pulse) else $error("rising tick missing");

	a_tick_fall: assert property (ce && s_reg.option[CFPS_OB_TSRC]
		&& s_reg.option[CFPS_OB_TEDGE] && s_reg.tick_prev && !ext_tick_pin
		|=> tick_pulse) else $error("falling tick missing");

	// pin two: quarter clock or the normal drive, never a mix
	a_qclk_value: assert property (ce && s_reg.trim[CFPS_TB_QCLK]
		|=> pin_two_o == $past(s_reg.qdiv[1])) else $error("quarter clock level wrong");

	a_norm_pin: assert property (ce && !s_reg.trim[CFPS_TB_QCLK]
		|=> pin_two_oe == $past(pin_two_norm_oe) && pin_two_o == $past(pin_two_norm_o))
		else $error("normal pin drive wrong");

	c_call_ret: cover property (ce && ex_valid && ex_op == CFPS_OP_CALL
		##[1:20] ce && ex_valid && ex_op == CFPS_OP_RETLIT);
	c_sub_borrow: cover property (ce && ex_valid && ex_op == CFPS_OP_SUB && ex_a < ex_b);
	c_ext_tick: cover property (tick_pulse && ext_tick_dir_override);
	c_other_rst: cover property (ce && sys_rst && rst_pin_wake);

endmodule : cfps_core

// file: verilog/cfps_pkg.sv
// Purpose: shared constants and types of the core flag, option, trim and pc block
// Assumes: one 100 MHz clock, registers reached over a plain strobe port
// Notes:   register offsets are local choices of this block
package cfps_pkg;

	// register port offsets
	localparam logic [1:0] CFPS_OFS_FLAGS  = 2'h0;
	localparam logic [1:0] CFPS_OFS_OPTION = 2'h1;
	localparam logic [1:0] CFPS_OFS_TRIM   = 2'h2;
	localparam logic [1:0] CFPS_OFS_PCLOW  = 2'h3;

	// flag register bit positions
	localparam int CFPS_FB_PINWAKE = 7;
	localparam int CFPS_FB_CMPWAKE = 6;
	localparam int CFPS_FB_TIMEOUT = 4;
	localparam int CFPS_FB_PWRDN   = 3;
	localparam int CFPS_FB_ZERO    = 2;
	localparam int CFPS_FB_DCARRY  = 1;
	localparam int CFPS_FB_CARRY   = 0;

	// option register bit positions
	localparam int CFPS_OB_WAKE_N  = 7;
	localparam int CFPS_OB_PULL_N  = 6;
	localparam int CFPS_OB_TSRC    = 5;
	localparam int CFPS_OB_TEDGE   = 4;
	localparam int CFPS_OB_PSA     = 3;

	// trim register bit positions
	localparam int CFPS_TB_QCLK    = 0;

	// reset values and flag write mask
	localparam logic [7:0] CFPS_RST_FLAGS  = 8'h18;
	localparam logic [7:0] CFPS_RST_OPTION = 8'hff;
	localparam logic [7:0] CFPS_RST_TRIM   = 8'hfe;
	localparam logic [7:0] CFPS_FLAG_WMASK = 8'hc7;

	// operations presented by the execution logic
	typedef enum logic [3:0] {
		CFPS_OP_NONE   = 4'h0,
		CFPS_OP_ADD    = 4'h1,
		CFPS_OP_SUB    = 4'h2,
		CFPS_OP_ROR    = 4'h3,
		CFPS_OP_ROL    = 4'h4,
		CFPS_OP_LOGIC  = 4'h5,
		CFPS_OP_JUMP   = 4'h6,
		CFPS_OP_CALL   = 4'h7,
		CFPS_OP_RETLIT = 4'h8,
		CFPS_OP_OPTION = 4'h9,
		CFPS_OP_WRPCL  = 4'ha,
		CFPS_OP_WATCHDOG_CLEAR_OP = 4'hb,
		CFPS_OP_SLEEP  = 4'hc
	} cfps_op_e;

endpackage : cfps_pkg

// file: verification/cfps_exec_model.sv
// Purpose: execution-side model driving one operation per call
// Assumes: ops are launched right after a rising edge and last one cycle
// Notes:   operand lines show inverted data once released
module cfps_exec_model
	import cfps_pkg::*;
(
	// clock
	input  wire logic       clk_sys,
	// literal return from the block
	input  wire logic [7:0] w_out,
	input  wire logic       w_load,
	// execution side
	output cfps_op_e        ex_op,
	output logic            ex_valid,
	output logic [7:0]      ex_a,
	output logic [7:0]      ex_b,
	output logic [8:0]      ex_lit,
	output logic [7:0]      w_in
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		ex_valid = 1'b0;
		ex_op    = CFPS_OP_NONE;
		ex_a     = 8'h00;
		ex_b     = 8'h00;
		ex_lit   = 9'h000;
		w_in     = 8'h00;
	end
	// working register follows each literal return
	always @(posedge clk_sys)
		if (w_load === 1'b1)
			w_in <= w_out;
	task automatic set_w(input logic [7:0] v);
		@(posedge clk_sys);
		w_in <= v;
	endtask : set_w
	task automatic exec(input cfps_op_e op, input logic [7:0] a, b, input logic [8:0] lit);
		@(posedge clk_sys);
		ex_valid <= 1'b1;
		ex_op    <= op;
		ex_a     <= a;
		ex_b     <= b;
		ex_lit   <= lit;
		@(posedge clk_sys);
		ex_valid <= 1'b0;
		ex_op    <= CFPS_OP_NONE;
		ex_a     <= ~a;
		ex_b     <= ~b;
		ex_lit   <= ~lit;
	endtask : exec
endmodule : cfps_exec_model

// file: verification/core_flags_pc_stack_test.sv
// Purpose: self-checking bench of the core flag, option, trim and pc block
// Assumes: cfps_exec_model stands in for the execution logic
// Notes:   random alu and branch traffic from a fixed seed, corners by hand
module core_flags_pc_stack_test
	import cfps_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk_sys = 1'b0, nrst = 1'b0, ce = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic       wdt_timeout = 1'b0, sys_rst = 1'b0, rst_pin_wake = 1'b0, rst_cmp_wake = 1'b0;
	logic       ext_tick_pin = 1'b0, pin_two_norm_o = 1'b0, pin_two_norm_oe = 1'b0;
	logic       ex_valid, w_load, tick_pulse, ext_tick_dir_override, prescale_to_wdt;
	logic       pin_two_o, pin_two_oe, z_e = 1'b0, dc_e = 1'b0, c_e = 1'b0;
	logic [1:0] reg_addr = 2'h0;
	logic [2:0] dir_ctrl = 3'h0, pin_wake_en, pullup_en;
	logic [3:0] tick_div_exp, wdt_div_exp;
	logic [6:0] osc_trim_value;
	logic [7:0] reg_wdata = 8'h00, reg_rdata, alu_result, w_out, w_in, ex_a, ex_b, r, v, fl;
	logic [8:0] ex_lit, pc, pc_e = 9'h1ff, s1 = 9'h000, s2 = 9'h000;
	cfps_op_e   ex_op;
	integer     seed = 32'h51a6_734a;
	int         errors = 0, comparisons = 0, ticks = 0, hi, i, k;
	cfps_op_e   ops [9] = '{CFPS_OP_ADD, CFPS_OP_SUB, CFPS_OP_ROR, CFPS_OP_ROL, CFPS_OP_LOGIC,
		CFPS_OP_JUMP, CFPS_OP_CALL, CFPS_OP_RETLIT, CFPS_OP_WRPCL};
	logic [7:0] tw [3] = '{8'he7, 8'hf7, 8'hc7};
	cfps_core dut (.clk_sys, .nrst, .ce, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.ex_valid, .ex_op, .ex_a, .ex_b, .ex_lit, .w_in, .wdt_timeout, .pc, .alu_result,
		.w_out, .w_load, .sys_rst, .rst_pin_wake, .rst_cmp_wake, .dir_ctrl, .ext_tick_pin,
		.pin_two_norm_o, .pin_two_norm_oe, .pin_wake_en, .pullup_en, .tick_pulse,
		.ext_tick_dir_override, .prescale_to_wdt, .tick_div_exp, .wdt_div_exp,
		.osc_trim_value, .pin_two_o, .pin_two_oe);
	cfps_exec_model m (.clk_sys, .w_out, .w_load, .ex_op, .ex_valid, .ex_a, .ex_b, .ex_lit,
		.w_in);
	always #5 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (tick_pulse === 1'b1)
			ticks <= ticks + 1;
	task automatic stop_test;
		if (errors == 0 && comparisons > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [15:0] got, exp);
		comparisons++;
		if (got !== exp)
		begin
			errors++;
			$display("Error at %0t: got %h, expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge clk_sys);
		reg_wr    <= 1'b0;
		reg_wdata <= ~d;
	endtask : wr
	task automatic rd(input logic [1:0] a, output logic [7:0] d);
		@(posedge clk_sys);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	// result, zero, digit carry, carry; rotates run through carry
	function automatic logic [10:0] alu(input cfps_op_e op, input logic [7:0] a, b,
		input logic [2:0] f);
		logic [7:0] s;
		s = (op == CFPS_OP_SUB) ? a - b : a + b;
		case (op)
			CFPS_OP_ADD: return {s, s == 8'h00, (a[3:0] + b[3:0]) > 5'h0f, s < a};
			CFPS_OP_SUB: return {s, s == 8'h00, a[3:0] >= b[3:0], a >= b};
			CFPS_OP_ROR: return {f[0], a[7:1], f[2:1], a[0]};
			CFPS_OP_ROL: return {a[6:0], f[0], f[2:1], a[7]};
			default:     return {a, a == 8'h00, f[1:0]};
		endcase
	endfunction : alu
	task automatic run(input cfps_op_e op, input logic [7:0] a, b, input logic [8:0] lit);
		logic [10:0] x;
		x = alu(op, a, b, {z_e, dc_e, c_e});
		m.exec(op, a, b, lit);
		#1;
		if (op == CFPS_OP_RETLIT)
		begin
			pc_e = s1;
			s1   = s2;
			chk(16'({w_load, w_out}), 16'({1'b1, lit[7:0]}));
		end
		else if (op == CFPS_OP_CALL)
		begin
			s2   = s1;
			s1   = pc_e + 9'h001;
			pc_e = {1'b0, lit[7:0]};
		end
		else if (op == CFPS_OP_JUMP)
			pc_e = lit;
		else if (op == CFPS_OP_WRPCL)
			pc_e = {1'b0, a};
		else
			pc_e = pc_e + 9'h001;
		chk(16'(pc), 16'(pc_e));
		if (op inside {CFPS_OP_ADD, CFPS_OP_SUB, CFPS_OP_ROR, CFPS_OP_ROL, CFPS_OP_LOGIC})
		begin
			{z_e, dc_e, c_e} = x[2:0];
			chk(16'(alu_result), 16'(x[10:3]));
			rd(CFPS_OFS_FLAGS, r);
			chk(16'(r[2:0]), 16'(x[2:0]));
		end
	endtask : run
	initial
	begin
		repeat (20000) @(posedge clk_sys);
		errors++;
		stop_test();
	end
	initial
	begin
		repeat (3) @(posedge clk_sys);
		nrst <= 1'b1;
		#1;
		chk(16'(pc), 16'h01ff);
		chk(16'({prescale_to_wdt, ext_tick_dir_override, tick_div_exp, wdt_div_exp}), 16'h0387);
		rd(CFPS_OFS_FLAGS, r);
		chk(16'(r), 16'(CFPS_RST_FLAGS));
		rd(CFPS_OFS_OPTION, r);
		chk(16'(r), 16'h0000);
		rd(CFPS_OFS_TRIM, r);
		chk(16'({osc_trim_value, r}), 16'({7'h7f, CFPS_RST_TRIM}));
		run(CFPS_OP_ADD, 8'hff, 8'h01, 9'h000);
		run(CFPS_OP_ADD, 8'h0f, 8'h01, 9'h000);
		run(CFPS_OP_SUB, 8'h05, 8'h05, 9'h000);
		run(CFPS_OP_SUB, 8'h10, 8'h01, 9'h000);
		run(CFPS_OP_ROR, 8'h01, 8'h00, 9'h000);
		run(CFPS_OP_ROL, 8'h80, 8'h00, 9'h000);
		for (i = 0; i < 200; i++)
			run(ops[$unsigned($random(seed)) % 9], 8'($random(seed)), 8'($random(seed)),
				9'($random(seed)));
		for (k = 0; k < 6; k++)
			run(k < 3 ? CFPS_OP_CALL : CFPS_OP_RETLIT, 8'h00, 8'h00, 9'($random(seed)));
		fork
			run(CFPS_OP_ADD, 8'hff, 8'h01, 9'h000);
			wr(CFPS_OFS_FLAGS, 8'h00);
		join
		run(CFPS_OP_SLEEP, 8'h00, 8'h00, 9'h000);
		rd(CFPS_OFS_FLAGS, fl);
		chk(16'(fl[4:3]), 16'h0002);
		v = 8'($random(seed));
		wr(CFPS_OFS_FLAGS, v);
		rd(CFPS_OFS_FLAGS, r);
		chk(16'(r), 16'((v & CFPS_FLAG_WMASK) | (fl & 8'h18)));
		@(posedge clk_sys);
		wdt_timeout <= 1'b1;
		@(posedge clk_sys);
		wdt_timeout <= 1'b0;
		rd(CFPS_OFS_FLAGS, r);
		chk(16'(r[4:3]), 16'h0000);
		run(CFPS_OP_WATCHDOG_CLEAR_OP, 8'h00, 8'h00, 9'h000);
		rd(CFPS_OFS_FLAGS, r);
		chk(16'(r[4:3]), 16'h0003);
		for (i = 0; i < 8; i++)
		begin
			r = 8'(i);
			@(posedge clk_sys);
			dir_ctrl <= 3'($random(seed));
			m.set_w({r[0], r[1], r[2], r[0], ~r[1], r[2:0]});
			run(CFPS_OP_OPTION, 8'h00, 8'h00, 9'h000);
			@(posedge clk_sys);
			#1;
			chk(16'({prescale_to_wdt, ext_tick_dir_override}), 16'({~r[1], r[2]}));
			chk(16'({tick_div_exp, wdt_div_exp}), 16'({r[3:0] + 4'h1, r[3:0]}));
			chk(16'({pin_wake_en, pullup_en}), 16'({r[0] ? 3'h0 : dir_ctrl,
				r[1] ? 3'h0 : dir_ctrl}));
		end
		// pin starts low: three toggles give two rises, then two falls
		for (k = 0; k < 3; k++)
		begin
			m.set_w(tw[k]);
			run(CFPS_OP_OPTION, 8'h00, 8'h00, 9'h000);
			@(posedge clk_sys);
			#1 ticks = 0;
			repeat (3)
			begin
				@(posedge clk_sys);
				ext_tick_pin <= ~ext_tick_pin;
				repeat (3) @(posedge clk_sys);
			end
			repeat (4) @(posedge clk_sys);
			#1;
			chk(16'(ticks), k < 2 ? 16'h0002 : 16'h0010);
		end
		for (i = 0; i < 3; i++)
		begin
			@(posedge clk_sys);
			sys_rst      <= 1'b1;
			rst_pin_wake <= (i == 1);
			rst_cmp_wake <= (i == 2);
			@(posedge clk_sys);
			sys_rst <= 1'b0;
			#1 pc_e = 9'h1ff;
			chk(16'(pc), 16'(pc_e));
			chk(16'({prescale_to_wdt, ext_tick_dir_override, tick_div_exp, wdt_div_exp}), 16'h0387);
			rd(CFPS_OFS_FLAGS, r);
			chk(16'(r[7:6]), 16'({i == 1, i == 2}));
		end
		v = 8'($random(seed)) | 8'h01;
		wr(CFPS_OFS_TRIM, v);
		rd(CFPS_OFS_TRIM, r);
		chk(16'({osc_trim_value, r}), 16'({v[7:1], v}));
		hi = 0;
		repeat (8)
		begin
			@(posedge clk_sys);
			#1 hi += int'(pin_two_o === 1'b1);
			chk(16'(pin_two_oe), 16'h0001);
		end
		chk(16'(hi), 16'h0004);
		wr(CFPS_OFS_TRIM, v & 8'hfe);
		{pin_two_norm_oe, pin_two_norm_o} <= 2'($random(seed));
		repeat (2) @(posedge clk_sys);
		#1;
		chk(16'({pin_two_oe, pin_two_o}), 16'({pin_two_norm_oe, pin_two_norm_o}));
		// clock enable low must swallow an executed jump
		@(posedge clk_sys);
		ce <= 1'b0;
		m.exec(CFPS_OP_JUMP, 8'h00, 8'h00, 9'h0a5);
		#1;
		chk(16'(pc), 16'(pc_e));
		@(posedge clk_sys);
		ce <= 1'b1;
		stop_test();
	end
endmodule : core_flags_pc_stack_test
